// ===== rtl/ctra_top.sv
// Transmit-request add register with pending vector and scan tracker, APB slave.
// Assumes a single 200 MHz clock and an APB master on the same clock.
// What this block does
// - Writing one raises that buffer's add request
// - Zero bits leave state untouched
// - Several bits accepted in one write
// - Only configured transmit buffers accept requests
// - No scan running: add bit clears at once
// - Scan running: add bit held until end
// - Read returns one while request waits
// - Request on already pending buffer ignored
// - New pending bit starts a priority scan
// - Pending cleared on completion or cancel
// - Bits set mid-scan excluded from that scan
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "ctra_consts.svh"
module ctra_top #(
    parameter int NBUF = 32,
    parameter int SCAN_CYC = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NBUF-1:0] tx_done,
    output logic [NBUF-1:0] tx_pending,
    output logic [NBUF-1:0] scan_set,
    output logic scan_active
);
    typedef struct packed {
        logic [NBUF-1:0] add_reg;
        logic [NBUF-1:0] cfg_reg;
        logic [NBUF-1:0] pend_reg;
        logic [NBUF-1:0] snap_reg;
        ctra_pkg::ctra_scan_t scan_reg;
        logic [7:0] cnt_reg;
        logic [31:0] rdata_reg;
    } ctra_state_t;

    ctra_state_t st_reg;
    ctra_state_t st_next;
    logic wr_acc;
    logic rd_acc;
    logic [NBUF-1:0] add_acc;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [NBUF-1:0] ctra_word(input logic [31:0] w);
        ctra_word = w[NBUF-1:0];
    endfunction : ctra_word

    function automatic logic ctra_hit(input logic [11:0] a, input logic [11:0] off);
        ctra_hit = (a == off);
    endfunction : ctra_hit

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    // Zero-wait slave: every access completes in its first access cycle
    assign wr_acc = psel && penable && pwrite && clk_en;
    assign rd_acc = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = st_reg.rdata_reg;
    assign tx_pending = st_reg.pend_reg;
    assign scan_set = st_reg.snap_reg;
    assign scan_active = (st_reg.scan_reg == ctra_pkg::CTRA_SCAN);

    // Filter write: configured and not already pending
    assign add_acc = (wr_acc && ctra_hit(paddr, `CTRA_OFF_ADD))
        ? (ctra_word(pwdata) & st_reg.cfg_reg & ~st_reg.pend_reg)
        : '0;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [NBUF-1:0] add_all;
        logic [NBUF-1:0] moved;
        add_all = '0;
        moved = '0;
        st_next = st_reg;
        add_all = st_reg.add_reg | add_acc;
        // Held while scanning, otherwise drained into pending at once
        if (st_reg.scan_reg == ctra_pkg::CTRA_SCAN) begin
            moved = '0;
        end else begin
            moved = add_all;
        end
        st_next.add_reg = add_all & ~moved;
        // Done/cancel clears; a fresh add wins over a same-cycle completion
        st_next.pend_reg = (st_reg.pend_reg & ~tx_done) | moved;
        case (st_reg.scan_reg)
            ctra_pkg::CTRA_IDLE: begin
                if (|moved) begin
                    st_next.scan_reg = ctra_pkg::CTRA_SCAN;
                    st_next.snap_reg = st_next.pend_reg;
                    st_next.cnt_reg = 8'(SCAN_CYC - 1);
                end
            end
            ctra_pkg::CTRA_SCAN: begin
                if (st_reg.cnt_reg == 8'h00) begin
                    st_next.scan_reg = ctra_pkg::CTRA_IDLE;
                    st_next.snap_reg = '0;
                end else begin
                    st_next.cnt_reg = st_reg.cnt_reg - 8'h01;
                end
            end
            default: begin
                st_next.scan_reg = ctra_pkg::CTRA_IDLE;
            end
        endcase
        if (wr_acc && ctra_hit(paddr, `CTRA_OFF_CFG)) begin
            st_next.cfg_reg = ctra_word(pwdata);
        end
        // Read data latched in setup, valid through the access cycle
        if (rd_acc && clk_en) begin
            st_next.rdata_reg = `CTRA_RST_WORD;
            if (ctra_hit(paddr, `CTRA_OFF_ADD)) begin
                st_next.rdata_reg[NBUF-1:0] = st_reg.add_reg;
            end else if (ctra_hit(paddr, `CTRA_OFF_CFG)) begin
                st_next.rdata_reg[NBUF-1:0] = st_reg.cfg_reg;
            end else if (ctra_hit(paddr, `CTRA_OFF_PEND)) begin
                st_next.rdata_reg[NBUF-1:0] = st_reg.pend_reg;
            end else if (ctra_hit(paddr, `CTRA_OFF_STAT)) begin
                st_next.rdata_reg[`CTRA_STAT_SCAN_BIT] = scan_active;
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Clock enable freezes everything
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Written bits land in the add register while a scan holds them
    chk_add_raise: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_acc && ctra_hit(paddr, `CTRA_OFF_ADD) && scan_active)
        |=> ((st_reg.add_reg & $past(pwdata[NBUF-1:0] & st_reg.cfg_reg & ~st_reg.pend_reg))
            == $past(pwdata[NBUF-1:0] & st_reg.cfg_reg & ~st_reg.pend_reg)))
        else $error("written add bit not raised");

    // Zero write on an empty add register raises nothing anywhere
    chk_zero_write: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_acc && ctra_hit(paddr, `CTRA_OFF_ADD) && pwdata == 32'h0000_0000 && st_reg.add_reg == '0)
        |=> ((st_reg.add_reg == '0) && ((st_reg.pend_reg & ~$past(st_reg.pend_reg)) == '0)))
        else $error("zero write raised request");

    // Several accepted bits reach pending together when idle
    chk_multi_carry: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_acc && ctra_hit(paddr, `CTRA_OFF_ADD) && !scan_active)
        |=> ((st_reg.pend_reg & $past(pwdata[NBUF-1:0] & st_reg.cfg_reg & ~st_reg.pend_reg))
            == $past(pwdata[NBUF-1:0] & st_reg.cfg_reg & ~st_reg.pend_reg)))
        else $error("accepted bits not all pending");

    // Buffer zero only goes pending if it was configured
    chk_unconf_dropped: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && $rose(st_reg.pend_reg[0])) |-> $past(st_reg.cfg_reg[0]))
        else $error("pending set on unconfigured buffer");

    // Whole-word form: unconfigured buffers never gain a request
    chk_unconf_word: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_acc && ctra_hit(paddr, `CTRA_OFF_ADD))
        |=> (((st_reg.add_reg | st_reg.pend_reg) & ~$past(st_reg.add_reg | st_reg.pend_reg)
            & $past(pwdata[NBUF-1:0] & ~st_reg.cfg_reg)) == '0))
        else $error("request raised on unconfigured buffer");

    // Idle: accepted bits never linger in the add register
    chk_idle_drain: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && !scan_active && |add_acc) |=> (st_reg.add_reg == '0))
        else $error("add bit kept while idle");

    // Busy: accepted bits stay visible until the scan ends
    chk_scan_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && scan_active && |add_acc) |=> ((st_reg.add_reg & $past(add_acc)) == $past(add_acc)))
        else $error("add bit dropped during scan");

    // Held bits are not released early: the scan runs its full count
    chk_scan_end: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && scan_active && st_reg.cnt_reg != 8'h00) |=> scan_active)
        else $error("scan ended before its count ran out");

    // Add-register reads show exactly the bits still waiting
    chk_read_add: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && rd_acc && ctra_hit(paddr, `CTRA_OFF_ADD))
        |=> (prdata[NBUF-1:0] == $past(st_reg.add_reg)))
        else $error("add read does not match held bits");

    // A request on a pending buffer leaves no trace in the add register
    chk_pend_ignore: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_acc && ctra_hit(paddr, `CTRA_OFF_ADD) && pwdata[0] && st_reg.pend_reg[0] && !st_reg.add_reg[0])
        |=> !st_reg.add_reg[0])
        else $error("add accepted on pending buffer");

    // A move into pending always kicks off a scan
    chk_scan_start: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && !scan_active && |add_acc) |=> scan_active)
        else $error("scan did not start");

    // Done or cancel clears pending unless a fresh add races it
    chk_done_clear: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && |(tx_done & ~add_acc & ~st_reg.add_reg))
        |=> ((st_reg.pend_reg & $past(tx_done & ~add_acc & ~st_reg.add_reg)) == '0))
        else $error("pending not cleared on done");

    // Scan set is taken once; later pending bits wait for the next scan
    chk_snap_frozen: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && scan_active && $past(scan_active) && $past(clk_en)) |-> $stable(st_reg.snap_reg))
        else $error("scan set changed mid-scan");

    // Idle drain of buffer zero lands in pending
    chk_pend_carry: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && !scan_active && add_acc[0] && !tx_done[0]) |=> st_reg.pend_reg[0])
        else $error("add not moved to pending");

    // Clock enable low holds every state bit, scan counter included
    chk_clk_en_freeze: assert property (@(posedge clk) disable iff (!arst_n)
        (!clk_en) |=> $stable(st_reg))
        else $error("state moved while clock enable low");
endmodule : ctra_top

// ===== rtl/ctra_consts.svh
// Constants for the transmit-request add block: register offsets, reset values.
// Assumes inclusion by bare name from design files.
`ifndef CTRA_CONSTS_SVH
`define CTRA_CONSTS_SVH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define CTRA_OFF_ADD 12'h000
`define CTRA_OFF_CFG 12'h004
`define CTRA_OFF_PEND 12'h008
`define CTRA_OFF_DONE 12'h00C
`define CTRA_OFF_STAT 12'h010
// ----------------------------------------
// Reset value and status bit position
// ----------------------------------------
`define CTRA_RST_WORD 32'h0000_0000
`define CTRA_STAT_SCAN_BIT 0
`endif

// ===== rtl/ctra_pkg.sv
// Types for the transmit-request add block.
// Assumes the constants header is included by the design file.
package ctra_pkg;
    typedef enum logic [1:0] {
        CTRA_IDLE = 2'b00,
        CTRA_SCAN = 2'b01
    } ctra_scan_t;
endpackage : ctra_pkg

// ===== testbench/ctra_top_tb.sv
// Bench for the transmit-request add block, driven over APB.
// Assumes the design constants header is on the include path.
`timescale 1ns/1ps
`include "ctra_consts.svh"
`define CHK(a, b) check_count++; if ((a) !== (b)) begin err_count++; $display("Error %0t: got %h exp %h", $time, a, b); end
module ctra_top_tb;
    logic clk = 0, arst_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, scan_active;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, tx_done = 32'h0, tx_pending, scan_set;
    int err_count = 0, check_count = 0;
    // Long scan so a mid-scan request is still held after several bus transfers
    ctra_top #(.NBUF(32), .SCAN_CYC(32)) dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_done(tx_done), .tx_pending(tx_pending), .scan_set(scan_set),
        .scan_active(scan_active));
    // ----------------------------------------
    // Bus and helper tasks
    // ----------------------------------------
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    // Idle edge first, so no signal is assigned twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        psel <= 0; penable <= 0;
        if (n >= 20) begin
            err_count++;
            tally_and_finish();
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
        `CHK(pslverr, 1'b0)
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask : rd
    // Bounded wait for the scan to finish
    task automatic wait_idle();
        int n;
        n = 0;
        while (scan_active !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            err_count++;
            tally_and_finish();
        end
    endtask : wait_idle
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_idle_add();
        rd(`CTRA_OFF_ADD, `CTRA_RST_WORD);
        rd(`CTRA_OFF_PEND, `CTRA_RST_WORD);
        wr(`CTRA_OFF_CFG, 32'h0000_00FF);
        wr(`CTRA_OFF_ADD, 32'h0000_0105);
        @(negedge clk);
        `CHK(scan_active, 1'b1)
        rd(`CTRA_OFF_ADD, 32'h0);
        rd(`CTRA_OFF_PEND, 32'h0000_0005);
    endtask : sc_idle_add
    task automatic sc_mid_scan();
        wr(`CTRA_OFF_ADD, 32'h0000_0010);
        rd(`CTRA_OFF_ADD, 32'h0000_0010);
        rd(`CTRA_OFF_PEND, 32'h0000_0005);
        rd(`CTRA_OFF_STAT, 32'h0000_0001);
        @(negedge clk);
        `CHK(scan_set, 32'h0000_0005)
        wait_idle();
        repeat (2) @(posedge clk);
        rd(`CTRA_OFF_ADD, 32'h0);
        rd(`CTRA_OFF_PEND, 32'h0000_0015);
        wait_idle();
    endtask : sc_mid_scan
    task automatic sc_dup_done();
        wr(`CTRA_OFF_ADD, 32'h0000_0001);
        repeat (3) @(posedge clk);
        `CHK(scan_active, 1'b0)
        rd(`CTRA_OFF_ADD, 32'h0);
        tx_done <= 32'h0000_0004;
        @(posedge clk);
        tx_done <= 32'h0;
        rd(`CTRA_OFF_PEND, 32'h0000_0011);
        wr(`CTRA_OFF_ADD, 32'h0);
        rd(`CTRA_OFF_PEND, 32'h0000_0011);
        rd(`CTRA_OFF_CFG, 32'h0000_00FF);
        rd(`CTRA_OFF_DONE, 32'h0);
        rd(12'h020, 32'h0);
    endtask : sc_dup_done
    // Clock enable low freezes a running scan and its vectors
    task automatic sc_freeze();
        wr(`CTRA_OFF_ADD, 32'h0000_0020);
        clk_en <= 1'b0;
        repeat (40) @(posedge clk);
        `CHK(scan_active, 1'b1)
        `CHK(tx_pending, 32'h0000_0031)
        `CHK(scan_set, 32'h0000_0031)
        clk_en <= 1'b1;
        wait_idle();
        `CHK(tx_pending, 32'h0000_0031)
        `CHK(scan_set, 32'h0)
    endtask : sc_freeze
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1;
        sc_idle_add();
        sc_mid_scan();
        sc_dup_done();
        sc_freeze();
        tally_and_finish();
    end
endmodule : ctra_top_tb
